// file: logic/bcab_pkg.sv
// Shared constants, encodings and carrier types for the branch/AND/bit-clear execution unit
package bcab_pkg;

  //////////////////////////////////////////////////////////////////////////////
  localparam int PC_W       = 21;
  localparam int DA_W       = 12;
  localparam int BSR_W      = 4;
  localparam int APB_AW     = 8;
  localparam int DMEM_DEPTH = 4096;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] OFS_INSTR    = 8'h04;
  localparam logic [APB_AW-1:0] OFS_WORK     = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATUS   = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_BANK     = 8'h10;
  localparam logic [APB_AW-1:0] OFS_PC       = 8'h14;
  localparam logic [APB_AW-1:0] OFS_INDEX    = 8'h18;
  localparam logic [APB_AW-1:0] OFS_MEM_ADDR = 8'h1C;
  localparam logic [APB_AW-1:0] OFS_MEM_DATA = 8'h20;
  localparam logic [APB_AW-1:0] OFS_STATE    = 8'h24;

  // Opcode fields
  localparam logic [7:0] OPC_BRC     = 8'hE2;
  localparam logic [5:0] OPC_AND     = 6'h05;
  localparam logic [3:0] OPC_BCLR    = 4'h9;
  localparam int         OPC8_LSB    = 8;
  localparam int         OPC6_LSB    = 10;
  localparam int         OPC4_LSB    = 12;
  localparam int         DEST_BIT    = 9;
  localparam int         ACC_BIT     = 8;
  localparam int         BITNO_LSB   = 9;
  localparam int         BITNO_MSB   = 11;

  // Addressing
  localparam logic [7:0]       ILO_MAX     = 8'h5F;
  localparam logic [BSR_W-1:0] ACC_LO_BANK = 4'h0;
  localparam logic [BSR_W-1:0] ACC_HI_BANK = 4'hF;

  // Status and control bits
  localparam int         ST_C        = 0;
  localparam int         ST_Z        = 2;
  localparam int         ST_N        = 4;
  localparam logic [7:0] STATUS_MASK = 8'h1F;
  localparam int         CTRL_EXT    = 0;
  localparam int         SB_BUSY     = 0;
  localparam int         SB_NOP      = 1;
  localparam int         SB_TAKEN    = 2;
  localparam int         SB_ILO      = 3;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    OP_NONE = 4'h1,
    OP_BRC  = 4'h2,
    OP_AND  = 4'h4,
    OP_BCLR = 4'h8
  } bcab_op_t;

  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_Q1   = 5'h02,
    PH_Q2   = 5'h04,
    PH_Q3   = 5'h08,
    PH_Q4   = 5'h10
  } bcab_phase_t;

  typedef struct packed {
    bcab_op_t   op;
    logic       to_file;
    logic       banked;
    logic [7:0] fadr;
    logic [2:0] bitno;
    logic [7:0] offs;
  } bcab_dec_t;

  typedef struct packed {
    logic [7:0]      res;
    logic [7:0]      status;
    logic            taken;
    logic [PC_W-1:0] pc_tgt;
  } bcab_alu_t;

  typedef struct packed {
    bcab_phase_t                phase;
    logic                       nop;
    logic [15:0]                instr;
    bcab_dec_t                  dec;
    logic [7:0]                 work;
    logic [7:0]                 status;
    logic [BSR_W-1:0]           bank_selector;
    logic [PC_W-1:0]            pc;
    logic [DA_W-1:0]            index;
    logic                       ext_en;
    logic [DA_W-1:0]            mem_addr;
    logic [DA_W-1:0]            ea;
    logic                       ilo;
    logic [7:0]                 opnd;
    bcab_alu_t                  alu;
    logic [31:0]                rdata;
    logic                       slverr;
    logic [DMEM_DEPTH-1:0][7:0] mem;
  } bcab_state_t;

endpackage

// file: logic/bcab_addr_resolve.sv
// File-register effective address: banked, access bank or indexed literal offset
`timescale 1ns/100ps
module bcab_addr_resolve
(
  input  wire logic [7:0]                fadr,
  input  wire logic                      banked,
  input  wire logic                      ext_en,
  input  wire logic [bcab_pkg::BSR_W-1:0] bank_selector,
  input  wire logic [bcab_pkg::DA_W-1:0]  index,
  output logic      [bcab_pkg::DA_W-1:0]  ea,
  output logic                           ilo
);

  always_comb
  begin
    ilo = 1'b0;
    if (banked)
    begin
      ea = {bank_selector, fadr};
    end
    else if (ext_en && (fadr <= bcab_pkg::ILO_MAX))
    begin
      // Index wraps inside data space rather than faulting
      ea  = index + {4'h0, fadr};
      ilo = 1'b1;
    end
    else if (fadr <= bcab_pkg::ILO_MAX)
    begin
      ea = {bcab_pkg::ACC_LO_BANK, fadr};
    end
    else
    begin
      ea = {bcab_pkg::ACC_HI_BANK, fadr};
    end
  end

endmodule

// file: logic/bcab_alu.sv
// Result, flag and branch target computation for the three supported operations
`timescale 1ns/100ps
module bcab_alu
(
  input  wire bcab_pkg::bcab_dec_t         dec,
  input  wire logic [7:0]                  work,
  input  wire logic [7:0]                  opnd,
  input  wire logic [7:0]                  status,
  input  wire logic [bcab_pkg::PC_W-1:0]   pc,
  output bcab_pkg::bcab_alu_t              alu
);

  always_comb
  begin
    alu        = '0;
    alu.status = status;
    // Pc has already stepped past the branch, so this is branch address + 2 + 2n
    alu.pc_tgt = pc + {{(bcab_pkg::PC_W-9){dec.offs[7]}}, dec.offs, 1'b0};
    unique case (dec.op)
      bcab_pkg::OP_AND:
      begin
        alu.res                      = work & opnd;
        alu.status[bcab_pkg::ST_Z]   = (alu.res == 8'h00);
        alu.status[bcab_pkg::ST_N]   = alu.res[7];
      end
      bcab_pkg::OP_BCLR:
      begin
        alu.res = opnd & ~(8'h01 << dec.bitno);
      end
      bcab_pkg::OP_BRC:
      begin
        alu.taken = status[bcab_pkg::ST_C];
      end
      bcab_pkg::OP_NONE:
      begin
      end
    endcase
  end

endmodule

// file: logic/bcab_exec.sv
// Execution unit for carry branch, AND into file and single bit clear, with APB registers
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module bcab_exec
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             busy
);

  //////////////////////////////////////////////////////////////////////////////
  bcab_pkg::bcab_state_t r;
  bcab_pkg::bcab_state_t s;
  bcab_pkg::bcab_alu_t   alu_out;
  logic [bcab_pkg::DA_W-1:0] ea_calc;
  logic                      ilo_calc;
  logic                      apb_setup;
  logic                      apb_wr;
  logic                      idle;
  logic [7:0]                op8;
  logic [5:0]                op6;
  logic [3:0]                op4;

  assign idle      = (r.phase == bcab_pkg::PH_IDLE);
  assign apb_setup = psel && !penable;
  // Zero wait states; a transfer already flagged at setup never lands
  assign apb_wr    = psel && penable && pwrite && idle && !r.slverr;
  assign pready    = 1'b1;
  assign prdata    = r.rdata;
  assign pslverr   = r.slverr && psel && penable;
  assign busy      = !idle;

  assign op8 = r.instr[15:bcab_pkg::OPC8_LSB];
  assign op6 = r.instr[15:bcab_pkg::OPC6_LSB];
  assign op4 = r.instr[15:bcab_pkg::OPC4_LSB];

  //////////////////////////////////////////////////////////////////////////////
  bcab_addr_resolve u_addr
  (
    .fadr          (r.dec.fadr),
    .banked        (r.dec.banked),
    .ext_en        (r.ext_en),
    .bank_selector (r.bank_selector),
    .index         (r.index),
    .ea            (ea_calc),
    .ilo           (ilo_calc)
  );

  bcab_alu u_alu
  (
    .dec    (r.dec),
    .work   (r.work),
    .opnd   (r.opnd),
    .status (r.status),
    .pc     (r.pc),
    .alu    (alu_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s = r;

    // Register read data and error are latched in the setup phase
    if (apb_setup)
    begin
      s.rdata  = 32'h00000000;
      s.slverr = 1'b0;
      unique case (paddr)
        bcab_pkg::OFS_CTRL:
        begin
          s.rdata[bcab_pkg::CTRL_EXT] = r.ext_en;
        end
        bcab_pkg::OFS_INSTR:
        begin
          s.rdata[15:0] = r.instr;
        end
        bcab_pkg::OFS_WORK:
        begin
          s.rdata[7:0] = r.work;
        end
        bcab_pkg::OFS_STATUS:
        begin
          s.rdata[7:0] = r.status;
        end
        bcab_pkg::OFS_BANK:
        begin
          s.rdata[bcab_pkg::BSR_W-1:0] = r.bank_selector;
        end
        bcab_pkg::OFS_PC:
        begin
          s.rdata[bcab_pkg::PC_W-1:0] = r.pc;
        end
        bcab_pkg::OFS_INDEX:
        begin
          s.rdata[bcab_pkg::DA_W-1:0] = r.index;
        end
        bcab_pkg::OFS_MEM_ADDR:
        begin
          s.rdata[bcab_pkg::DA_W-1:0] = r.mem_addr;
        end
        bcab_pkg::OFS_MEM_DATA:
        begin
          s.rdata[7:0] = r.mem[r.mem_addr];
        end
        bcab_pkg::OFS_STATE:
        begin
          s.rdata[bcab_pkg::SB_BUSY]  = !idle;
          s.rdata[bcab_pkg::SB_NOP]   = r.nop;
          s.rdata[bcab_pkg::SB_TAKEN] = r.alu.taken;
          s.rdata[bcab_pkg::SB_ILO]   = r.ilo;
        end
        default:
        begin
          s.slverr = 1'b1;
        end
      endcase
      // State would race the running instruction, so writes while busy are refused with an error
      if (pwrite && !idle)
      begin
        s.slverr = 1'b1;
      end
    end

    // Register writes, only while no instruction runs
    if (apb_wr)
    begin
      unique case (paddr)
        bcab_pkg::OFS_CTRL:
        begin
          s.ext_en = pwdata[bcab_pkg::CTRL_EXT];
        end
        bcab_pkg::OFS_INSTR:
        begin
          s.instr = pwdata[15:0];
          s.phase = bcab_pkg::PH_Q1;
          s.nop   = 1'b0;
        end
        bcab_pkg::OFS_WORK:
        begin
          s.work = pwdata[7:0];
        end
        bcab_pkg::OFS_STATUS:
        begin
          s.status = pwdata[7:0] & bcab_pkg::STATUS_MASK;
        end
        bcab_pkg::OFS_BANK:
        begin
          s.bank_selector = pwdata[bcab_pkg::BSR_W-1:0];
        end
        bcab_pkg::OFS_PC:
        begin
          // Instructions are halfword aligned
          s.pc = {pwdata[bcab_pkg::PC_W-1:1], 1'b0};
        end
        bcab_pkg::OFS_INDEX:
        begin
          s.index = pwdata[bcab_pkg::DA_W-1:0];
        end
        bcab_pkg::OFS_MEM_ADDR:
        begin
          s.mem_addr = pwdata[bcab_pkg::DA_W-1:0];
        end
        bcab_pkg::OFS_MEM_DATA:
        begin
          s.mem[r.mem_addr] = pwdata[7:0];
        end
        default:
        begin
        end
      endcase
    end

    // Four pclk phases make one instruction cycle
    unique case (r.phase)
      bcab_pkg::PH_IDLE:
      begin
      end
      bcab_pkg::PH_Q1:
      begin
        s.phase = bcab_pkg::PH_Q2;
        if (!r.nop)
        begin
          s.dec.op      = bcab_pkg::OP_NONE;
          s.dec.to_file = r.instr[bcab_pkg::DEST_BIT];
          s.dec.banked  = r.instr[bcab_pkg::ACC_BIT];
          s.dec.fadr    = r.instr[7:0];
          s.dec.bitno   = r.instr[bcab_pkg::BITNO_MSB:bcab_pkg::BITNO_LSB];
          s.dec.offs    = r.instr[7:0];
          s.alu.taken   = 1'b0;
          if (op8 == bcab_pkg::OPC_BRC)
          begin
            s.dec.op = bcab_pkg::OP_BRC;
          end
          else if (op6 == bcab_pkg::OPC_AND)
          begin
            s.dec.op = bcab_pkg::OP_AND;
          end
          else if (op4 == bcab_pkg::OPC_BCLR)
          begin
            s.dec.op = bcab_pkg::OP_BCLR;
          end
          // Fetch of the next word advances pc before any branch target is formed
          s.pc = r.pc + bcab_pkg::PC_STEP;
        end
      end
      bcab_pkg::PH_Q2:
      begin
        s.phase = bcab_pkg::PH_Q3;
        if (!r.nop)
        begin
          s.ea   = ea_calc;
          s.ilo  = ilo_calc;
          s.opnd = r.mem[ea_calc];
        end
      end
      bcab_pkg::PH_Q3:
      begin
        s.phase = bcab_pkg::PH_Q4;
        if (!r.nop)
        begin
          s.alu = alu_out;
        end
      end
      bcab_pkg::PH_Q4:
      begin
        s.phase = bcab_pkg::PH_IDLE;
        s.nop   = 1'b0;
        if (!r.nop)
        begin
          unique case (r.dec.op)
            bcab_pkg::OP_AND:
            begin
              s.status = r.alu.status;
              if (r.dec.to_file)
              begin
                s.mem[r.ea] = r.alu.res;
              end
              else
              begin
                s.work = r.alu.res;
              end
            end
            bcab_pkg::OP_BCLR:
            begin
              s.mem[r.ea] = r.alu.res;
            end
            bcab_pkg::OP_BRC:
            begin
              if (r.alu.taken)
              begin
                s.pc    = r.alu.pc_tgt;
                s.phase = bcab_pkg::PH_Q1;
                s.nop   = 1'b1;
              end
            end
            bcab_pkg::OP_NONE:
            begin
            end
          endcase
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r               <= '0;
      r.phase         <= bcab_pkg::PH_IDLE;
      r.dec.op        <= bcab_pkg::OP_NONE;
    end
    else
    begin
      r <= s;
    end
  end

endmodule

// file: tb/bcab_exec_monitor.sv
// Port-level checker for the execution unit, bound to its top module
`timescale 1ns/100ps
module bcab_exec_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire go  = acc && pwrite && !busy && paddr == bcab_pkg::OFS_INSTR;
  sequence s_one;
    busy [*4] ##1 !busy;
  endsequence
  sequence s_two;
    busy [*8] ##1 !busy;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_and_len: assert property (go && pwdata[15:10] == bcab_pkg::OPC_AND |=> s_one)
    else $error("AND took the wrong number of cycles");
  a_clear_len: assert property (go && pwdata[15:12] == bcab_pkg::OPC_BCLR |=> s_one)
    else $error("bit clear took the wrong number of cycles");
  a_branch_len: assert property (go && pwdata[15:8] == bcab_pkg::OPC_BRC |=> s_one or s_two)
    else $error("branch took neither one nor two cycles");
  a_state_busy: assert property (acc && !pwrite && paddr == bcab_pkg::OFS_STATE
    |-> prdata[0] == $past(busy)) else $error("state busy bit disagrees with busy");
  a_busy_refuse: assert property (acc && pwrite && busy |-> pslverr)
    else $error("write while busy not refused");
  a_unmapped_err: assert property (acc && paddr > bcab_pkg::OFS_STATE |-> pslverr)
    else $error("unmapped access not flagged");
  a_err_gated: assert property (pslverr |-> acc)
    else $error("error flag outside access phase");
  a_ready_high: assert property (pready)
    else $error("ready dropped");
endmodule

bind bcab_exec bcab_exec_monitor bcab_exec_monitor_inst
(
  .pclk    (pclk),
  .presetn (presetn),
  .psel    (psel),
  .penable (penable),
  .pwrite  (pwrite),
  .paddr   (paddr),
  .pwdata  (pwdata),
  .pready  (pready),
  .prdata  (prdata),
  .pslverr (pslverr),
  .busy    (busy)
);

// file: tb/branch_carry_and_bitclear_ops_tb_top.sv
// Directed bench for the execution unit, driven over APB
`timescale 1ns/100ps
module branch_carry_and_bitclear_ops_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        busy;
  logic [31:0] rd_v;
  logic        err_v;
  logic [7:0]  res;
  logic [20:0] pexp;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc;
  always #5 pclk = ~pclk;
  bcab_exec bcab_exec_inst
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .busy    (busy)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read data and error are taken at the same edge that sees pready high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic setm(input logic [11:0] a, input logic [7:0] d);
    wr(bcab_pkg::OFS_MEM_ADDR, {20'h0, a});
    wr(bcab_pkg::OFS_MEM_DATA, {24'h0, d});
  endtask
  task automatic getm(input logic [11:0] a);
    wr(bcab_pkg::OFS_MEM_ADDR, {20'h0, a});
    rd(bcab_pkg::OFS_MEM_DATA);
  endtask
  // Counts busy cycles after the instruction write; sampled 1 ns past each edge
  task automatic run(input logic [15:0] ins, input logic [31:0] cycles);
    wr(bcab_pkg::OFS_INSTR, {16'h0, ins});
    cyc = 0;
    #1;
    while (busy === 1'b1 && cyc < 20)
    begin
      cyc++;
      @(posedge pclk);
      #1;
    end
    check("busy cycles", cyc, cycles);
  endtask
  task automatic and_case(input logic ext, input logic [3:0] bank, input logic [11:0] ea,
                          input logic [7:0] w, input logic [7:0] m, input logic [15:0] ins);
    wr(bcab_pkg::OFS_CTRL, {31'h0, ext});
    wr(bcab_pkg::OFS_BANK, {28'h0, bank});
    wr(bcab_pkg::OFS_INDEX, 32'h100);
    wr(bcab_pkg::OFS_WORK, {24'h0, w});
    wr(bcab_pkg::OFS_STATUS, 32'h0F);
    setm(ea, m);
    run(ins, 1 * 4);
    res = w & m;
    rd(bcab_pkg::OFS_WORK);
    check("work", rd_v, {24'h0, ins[9] ? w : res});
    getm(ea);
    check("file", rd_v, {24'h0, ins[9] ? res : m});
    rd(bcab_pkg::OFS_STATUS);
    check("status", rd_v, {27'h0, res[7], 1'b1, res == 8'h00, 2'b11});
    rd(bcab_pkg::OFS_STATE);
    check("indexed", {31'h0, rd_v[bcab_pkg::SB_ILO]},
          {31'h0, ext && !ins[8] && (ins[7:0] <= bcab_pkg::ILO_MAX)});
  endtask
  task automatic br_case(input logic [20:0] base, input logic c, input logic [7:0] off);
    wr(bcab_pkg::OFS_PC, {11'h0, base});
    wr(bcab_pkg::OFS_STATUS, {31'h0, c});
    run({bcab_pkg::OPC_BRC, off}, c ? 8 : 4);
    pexp = base + bcab_pkg::PC_STEP + (c ? {{12{off[7]}}, off, 1'b0} : 21'h0);
    rd(bcab_pkg::OFS_PC);
    check("pc", rd_v, {11'h0, pexp});
    rd(bcab_pkg::OFS_STATE);
    check("taken", {31'h0, rd_v[bcab_pkg::SB_TAKEN]}, {31'h0, c});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(bcab_pkg::OFS_PC);
    check("pc reset", rd_v, 32'h0);
    and_case(1'b0, 4'h0, 12'h020, 8'h17, 8'hC2, 16'h1420);
    and_case(1'b0, 4'h3, 12'h345, 8'h3C, 8'hF0, 16'h1745);
    and_case(1'b0, 4'h3, 12'hFA0, 8'h80, 8'h81, 16'h16A0);
    and_case(1'b1, 4'h3, 12'h15F, 8'h0F, 8'hF0, 16'h145F);
    and_case(1'b1, 4'h3, 12'hF60, 8'hFF, 8'h5A, 16'h1660);
    wr(bcab_pkg::OFS_CTRL, 32'h0);
    wr(bcab_pkg::OFS_STATUS, 32'h1F);
    setm(12'h030, 8'hC7);
    run(16'h9E30, 4);
    getm(12'h030);
    check("clear b7", rd_v, 32'h47);
    run(16'h9945, 4);
    getm(12'h345);
    check("clear b4", rd_v, 32'h20);
    rd(bcab_pkg::OFS_STATUS);
    check("flags kept", rd_v, 32'h1F);
    br_case(21'h000100, 1'b0, 8'h05);
    br_case(21'h000100, 1'b1, 8'h05);
    br_case(21'h000200, 1'b1, 8'h80);
    br_case(21'h000200, 1'b1, 8'h7F);
    br_case(21'h000200, 1'b0, 8'h80);
    // Write landing while busy must be refused and leave work alone
    wr(bcab_pkg::OFS_WORK, 32'h11);
    wr(bcab_pkg::OFS_INSTR, 32'h0);
    wr(bcab_pkg::OFS_WORK, 32'hAA);
    check("busy write err", {31'h0, err_v}, 32'h00000001);
    repeat (6) @(posedge pclk);
    rd(bcab_pkg::OFS_WORK);
    check("work kept", rd_v, 32'h11);
    rd(8'h40);
    check("unmapped err", {31'h0, err_v}, 32'h00000001);
    check("unmapped data", rd_v, 32'h0);
    wrap_up;
  end
endmodule
